// ==== rtl/rtcs_top.sv ====
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module rtcs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic refresh_enable,
  input wire logic refresh_mode_select,
  input wire logic refresh_done,
  output logic refresh_req,
  output logic cmi_req,
  output logic ovi_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic cmf_q;
  logic cmf_d;
  logic compare_match_irq_enable_q;
  logic [2:0] cks_q;
  logic ovf_q;
  logic ovf_d;
  logic refresh_overflow_irq_enable_q;
  logic refresh_limit_select_q;
  logic cmf_arm_q;
  logic cmf_arm_d;
  logic [rtcs_pkg::ICNT_W-1:0] icnt_q;
  logic [rtcs_pkg::ICNT_W-1:0] icnt_d;
  logic [rtcs_pkg::ICNT_W-1:0] iconst_q;
  logic [rtcs_pkg::RCNT_W-1:0] rcnt_q;
  logic [rtcs_pkg::RCNT_W-1:0] rcnt_d;
  logic [rtcs_pkg::IRQ_W-1:0] irq_status_q;
  logic [rtcs_pkg::IRQ_W-1:0] irq_mask_q;
  logic refresh_req_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic wr_acc;
  logic word_wr;
  logic key_ok;
  logic key_rcnt_ok;
  logic sel_csr;
  logic sel_icnt;
  logic sel_iconst;
  logic sel_rcnt;
  logic sel_ist;
  logic sel_imask;
  logic mapped;
  logic wr_csr;
  logic wr_icnt;
  logic wr_iconst;
  logic wr_rcnt;
  logic wr_ist;
  logic wr_imask;
  logic [15:0] csr_rd;
  logic [31:0] rd_mux;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  // only a write carrying both low byte lanes counts as a word write
  assign word_wr = (pstrb[1:0] == 2'b11);
  assign key_ok = (pwdata[15:8] == rtcs_pkg::WR_KEY);
  assign key_rcnt_ok = (pwdata[15:10] == rtcs_pkg::WR_KEY_RCNT);

  assign sel_csr = (paddr == rtcs_pkg::OFF_CSR);
  assign sel_icnt = (paddr == rtcs_pkg::OFF_ICNT);
  assign sel_iconst = (paddr == rtcs_pkg::OFF_ICONST);
  assign sel_rcnt = (paddr == rtcs_pkg::OFF_RCNT);
  assign sel_ist = (paddr == rtcs_pkg::OFF_IRQ_STATUS);
  assign sel_imask = (paddr == rtcs_pkg::OFF_IRQ_MASK);
  assign mapped = sel_csr || sel_icnt || sel_iconst || sel_rcnt || sel_ist || sel_imask;

  // a wrong key or a byte write to a keyed register falls through with no effect at all; status and mask take a lane 0 write
  assign wr_csr = wr_acc && sel_csr && word_wr && key_ok;
  assign wr_icnt = wr_acc && sel_icnt && word_wr && key_ok;
  assign wr_iconst = wr_acc && sel_iconst && word_wr && key_ok;
  assign wr_rcnt = wr_acc && sel_rcnt && word_wr && key_rcnt_ok;
  assign wr_ist = wr_acc && sel_ist && pstrb[0];
  assign wr_imask = wr_acc && sel_imask && pstrb[0];

  // ----------------------------------------------------------------
  // count clock and interval counter
  // ----------------------------------------------------------------
  logic tick;
  logic match_ev;

  rtcs_prescaler #(
    .W(rtcs_pkg::PRESCALE_W)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .sel(cks_q),
    .tick(tick)
  );

  // compare happens on each count tick, so a stopped clock never matches
  assign match_ev = tick && (icnt_q == iconst_q);

  always_comb begin
    icnt_d = icnt_q;
    if (wr_icnt) begin
      icnt_d = pwdata[rtcs_pkg::ICNT_W-1:0];
    end else if (match_ev) begin
      icnt_d = '0;
    end else if (tick) begin
      icnt_d = icnt_q + rtcs_pkg::ICNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // refresh request counter and overflow
  // ----------------------------------------------------------------
  logic [10:0] limit;
  logic [10:0] rcnt_inc;
  logic ovf_ev;

  assign limit = refresh_limit_select_q ? rtcs_pkg::LIMIT_SHORT : rtcs_pkg::LIMIT_LONG;
  assign rcnt_inc = {1'b0, rcnt_q} + 11'h001;
  // the count would pass the last value below the limit
  assign ovf_ev = match_ev && (rcnt_inc >= limit);

  always_comb begin
    rcnt_d = rcnt_q;
    if (wr_rcnt) begin
      rcnt_d = pwdata[rtcs_pkg::RCNT_W-1:0];
    end else if (ovf_ev) begin
      rcnt_d = '0;
    end else if (match_ev) begin
      rcnt_d = rcnt_inc[rtcs_pkg::RCNT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  logic auto_refresh;
  logic cmf_wr0;
  logic cmf_clr;

  assign auto_refresh = refresh_enable && !refresh_mode_select;
  assign cmf_wr0 = wr_csr && !pwdata[rtcs_pkg::CMF_BIT];
  // clearing waits for the refresh that follows the written zero
  assign cmf_clr = cmf_arm_q && refresh_done && auto_refresh;

  always_comb begin
    cmf_d = cmf_q;
    cmf_arm_d = cmf_arm_q;
    if (cmf_wr0) begin
      cmf_arm_d = 1'b1;
    end
    if (cmf_clr) begin
      cmf_d = 1'b0;
      cmf_arm_d = 1'b0;
    end
    // a match in the clearing cycle still sets the flag; writing one is no-op
    if (match_ev) begin
      cmf_d = 1'b1;
    end
  end

  always_comb begin
    ovf_d = ovf_q;
    if (wr_csr && !pwdata[rtcs_pkg::OVF_BIT]) begin
      ovf_d = 1'b0;
    end
    if (ovf_ev) begin
      ovf_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // control/status register
  // ----------------------------------------------------------------
  // power-on reset only: no manual-reset or standby input reaches these
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmf_q <= rtcs_pkg::CSR_RESET[rtcs_pkg::CMF_BIT];
      compare_match_irq_enable_q <= rtcs_pkg::CSR_RESET[rtcs_pkg::COMPARE_MATCH_IRQ_ENABLE_BIT];
      cks_q <= rtcs_pkg::CSR_RESET[rtcs_pkg::CKS_MSB:rtcs_pkg::CKS_LSB];
      ovf_q <= rtcs_pkg::CSR_RESET[rtcs_pkg::OVF_BIT];
      refresh_overflow_irq_enable_q <= rtcs_pkg::CSR_RESET[rtcs_pkg::REFRESH_OVERFLOW_IRQ_ENABLE_BIT];
      refresh_limit_select_q <= rtcs_pkg::CSR_RESET[rtcs_pkg::REFRESH_LIMIT_SELECT_BIT];
      cmf_arm_q <= 1'b0;
    end else begin
      cmf_q <= cmf_d;
      ovf_q <= ovf_d;
      cmf_arm_q <= cmf_arm_d;
      if (wr_csr) begin
        compare_match_irq_enable_q <= pwdata[rtcs_pkg::COMPARE_MATCH_IRQ_ENABLE_BIT];
        cks_q <= pwdata[rtcs_pkg::CKS_MSB:rtcs_pkg::CKS_LSB];
        refresh_overflow_irq_enable_q <= pwdata[rtcs_pkg::REFRESH_OVERFLOW_IRQ_ENABLE_BIT];
        refresh_limit_select_q <= pwdata[rtcs_pkg::REFRESH_LIMIT_SELECT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // counters, constant, interrupt registers
  // ----------------------------------------------------------------
  logic [rtcs_pkg::IRQ_W-1:0] irq_set;
  logic [rtcs_pkg::IRQ_W-1:0] irq_w1c;

  assign irq_set = {ovf_ev, match_ev};
  assign irq_w1c = wr_ist ? pwdata[rtcs_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icnt_q <= '0;
      iconst_q <= '0;
      rcnt_q <= '0;
      irq_status_q <= '0;
      irq_mask_q <= '0;
    end else begin
      icnt_q <= icnt_d;
      rcnt_q <= rcnt_d;
      if (wr_iconst) begin
        iconst_q <= pwdata[rtcs_pkg::ICNT_W-1:0];
      end
      // a new event beats a same-cycle clear
      irq_status_q <= (irq_status_q & ~irq_w1c) | irq_set;
      if (wr_imask) begin
        irq_mask_q <= pwdata[rtcs_pkg::IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // refresh start and interrupt requests
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_req_q <= 1'b0;
    end else begin
      refresh_req_q <= match_ev && auto_refresh;
    end
  end

  assign refresh_req = refresh_req_q;
  // cmi_req and ovi_req follow the flags, irq the status register gated by mask and enable bits; software avoids compare_match_irq_enable with auto refresh
  assign cmi_req = cmf_q && compare_match_irq_enable_q;
  assign ovi_req = ovf_q && refresh_overflow_irq_enable_q;
  assign irq = |(irq_status_q & irq_mask_q & {refresh_overflow_irq_enable_q, compare_match_irq_enable_q});

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // upper byte is hard zero whatever was written
  assign csr_rd = {8'h00, cmf_q, compare_match_irq_enable_q, cks_q, ovf_q, refresh_overflow_irq_enable_q, refresh_limit_select_q};

  assign rd_mux = sel_csr ? {16'h0000, csr_rd} :
                  sel_icnt ? {24'h000000, icnt_q} :
                  sel_iconst ? {24'h000000, iconst_q} :
                  sel_rcnt ? {22'h0, rcnt_q} :
                  sel_ist ? {30'h0, irq_status_q} :
                  sel_imask ? {30'h0, irq_mask_q} :
                  32'h00000000;

  // read data captured in the setup phase so it is a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_q <= !mapped;
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

endmodule

// ==== rtl/rtcs_pkg.sv ====
// Behaviour
// - control/status register is 16 bits, cleared to zero only by power-on reset
// - writes need a full word with key in upper byte; byte writes ignored
// - bits 15..8 and undefined bits read zero; software writes the key to 15..8
// - compare-match flag, bit 7, sets when interval counter equals constant
// - compare-match flag clears on auto refresh done after zero written
// - writing one to the compare-match flag leaves it unchanged
// - bit 6 gates the compare-match interrupt request
// - bits 5..3 select counter clock: stop, or bus clock divided 4..4096
// - overflow flag, bit 2, sets when request count exceeds selected limit
// - overflow flag clears on written zero; written one leaves it unchanged
// - bit 1 gates the overflow interrupt request
// - bit 0 selects count limit: zero gives 1024, one gives 512
// - 8-bit interval counter counts up, on match sets flag and clears
// - 10-bit request counter increments per match, clears on overflow
// - flag setting with refresh enabled and auto mode starts a refresh
package rtcs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CSR = 8'h00;
  localparam logic [7:0] OFF_ICNT = 8'h04;
  localparam logic [7:0] OFF_ICONST = 8'h08;
  localparam logic [7:0] OFF_RCNT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // write keys
  // ----------------------------------------------------------------
  localparam logic [7:0] WR_KEY = 8'ha5;
  localparam logic [5:0] WR_KEY_RCNT = 6'h29;

  // ----------------------------------------------------------------
  // control/status fields
  // ----------------------------------------------------------------
  localparam int CMF_BIT = 7;
  localparam int COMPARE_MATCH_IRQ_ENABLE_BIT = 6;
  localparam int CKS_MSB = 5;
  localparam int CKS_LSB = 3;
  localparam int OVF_BIT = 2;
  localparam int REFRESH_OVERFLOW_IRQ_ENABLE_BIT = 1;
  localparam int REFRESH_LIMIT_SELECT_BIT = 0;
  localparam logic [15:0] CSR_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // counters and limits
  // ----------------------------------------------------------------
  localparam int ICNT_W = 8;
  localparam int RCNT_W = 10;
  localparam logic [10:0] LIMIT_LONG = 11'h400;
  localparam logic [10:0] LIMIT_SHORT = 11'h200;
  localparam int PRESCALE_W = 12;

  // ----------------------------------------------------------------
  // interrupt status/mask bits
  // ----------------------------------------------------------------
  localparam int IRQ_CM = 0;
  localparam int IRQ_OV = 1;
  localparam int IRQ_W = 2;

  typedef enum logic [2:0] {
    CKS_STOP = 3'h0,
    CKS_DIV4 = 3'h1,
    CKS_DIV16 = 3'h2,
    CKS_DIV64 = 3'h3,
    CKS_DIV256 = 3'h4,
    CKS_DIV1024 = 3'h5,
    CKS_DIV2048 = 3'h6,
    CKS_DIV4096 = 3'h7
  } rtcs_cks_t;

  // log2 of the division ratio; zero for the stopped setting
  function automatic logic [3:0] div_log2(input rtcs_cks_t sel);
    logic [3:0] r;
    r = 4'h0;
    unique case (sel)
      CKS_STOP: r = 4'h0;
      CKS_DIV4: r = 4'h2;
      CKS_DIV16: r = 4'h4;
      CKS_DIV64: r = 4'h6;
      CKS_DIV256: r = 4'h8;
      CKS_DIV1024: r = 4'ha;
      CKS_DIV2048: r = 4'hb;
      CKS_DIV4096: r = 4'hc;
    endcase
    return r;
  endfunction

endpackage

// ==== rtl/rtcs_prescaler.sv ====
`timescale 1ns/1ps
module rtcs_prescaler #(
  parameter int W = rtcs_pkg::PRESCALE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] sel,
  output logic tick
);

  // ----------------------------------------------------------------
  // free-running divider shared by every ratio
  // ----------------------------------------------------------------
  logic [W-1:0] cnt_q;
  logic [W-1:0] mask;
  logic stopped;

  // one pclk-wide tick each time the low log2(ratio) bits roll over
  assign mask = W'((32'h1 << rtcs_pkg::div_log2(rtcs_pkg::rtcs_cks_t'(sel))) - 32'h1);
  assign stopped = (sel == rtcs_pkg::CKS_STOP);
  assign tick = !stopped && ((cnt_q & mask) == mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

endmodule

// ==== verif/rtcs_assertions.sv ====
`timescale 1ns/1ps
module rtcs_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic refresh_enable,
  input wire logic refresh_mode_select,
  input wire logic refresh_done,
  input wire logic refresh_req,
  input wire logic cmi_req,
  input wire logic ovi_req,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // bus, flag and refresh checks
  // ----------------------------------------
  a_err_unmapped: assert property (psel && !penable && paddr > 8'h14 |=> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (psel && !penable && paddr <= 8'h14 &&
    paddr[1:0] == 2'h0 |=> !pslverr) else $error("error on mapped access");
  a_err_rdata_zero: assert property (psel && penable && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (psel && penable && !pwrite &&
    paddr == rtcs_pkg::OFF_CSR |-> prdata[31:8] == 24'h0) else $error("upper bits not zero");
  a_req_spacing: assert property (refresh_req |=> !refresh_req [*3])
    else $error("refresh requests too close");
  a_req_auto: assert property (refresh_req |->
    $past(refresh_enable) && !$past(refresh_mode_select))
    else $error("refresh request outside auto mode");
  a_ovi_fall: assert property ($fell(ovi_req) |->
    $past(psel) && $past(penable) && $past(pwrite))
    else $error("overflow request dropped without write");
  a_cmi_fall: assert property ($fell(cmi_req) |->
    $past(refresh_done) || ($past(psel) && $past(pwrite)))
    else $error("match request dropped without cause");
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  c_refresh: cover property (refresh_req);
  c_ovi: cover property ($rose(ovi_req));
  c_irq: cover property ($rose(irq));
endmodule

bind rtcs_top rtcs_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .refresh_enable(refresh_enable),
  .refresh_mode_select(refresh_mode_select), .refresh_done(refresh_done),
  .refresh_req(refresh_req), .cmi_req(cmi_req), .ovi_req(ovi_req), .irq(irq));

// ==== verif/tb_refresh_timer_control_status.sv ====
`timescale 1ns/1ps
module tb_refresh_timer_control_status;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, refresh_done = 1'b0;
  logic refresh_enable = 1'b1, refresh_mode_select = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, refresh_req, cmi_req, ovi_req, irq, ev;
  logic [7:0] v, kk, last;
  logic [10:0] lim;
  int error_cnt = 0;
  int comparisons = 0;
  int n;

  always #2.5 pclk = ~pclk;

  rtcs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .refresh_enable(refresh_enable),
    .refresh_mode_select(refresh_mode_select), .refresh_done(refresh_done),
    .refresh_req(refresh_req), .cmi_req(cmi_req), .ovi_req(ovi_req), .irq(irq));

  // ----------------------------------------
  // bus tasks and expectations
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rv, x);
  endtask

  // flags are looked at one edge after the write lands
  // s picks the output: 0 match request, 1 irq, 2 overflow request
  task automatic chkb(input int s, input logic x);
    @(posedge pclk);
    chk({31'h0, (s == 0) ? cmi_req : (s == 1) ? irq : ovi_req}, {31'h0, x});
  endtask

  task automatic wreq();
    do @(posedge pclk); while (refresh_req !== 1'b1);
  endtask

  task automatic pulse_done();
    refresh_done <= 1'b1;
    @(posedge pclk);
    refresh_done <= 1'b0;
  endtask

  function automatic logic [31:0] period(input int k, input int c);
    return (k < 5) ? 32'((c + 1) << (2 * k)) : 32'((c + 1) << (k + 5));
  endfunction

  function automatic logic [31:0] csr(input logic [7:0] x);
    return {16'h0, rtcs_pkg::WR_KEY, x};
  endfunction

  task automatic finish_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    finish_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rv = $urandom(32'h7b78);
    last = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(rtcs_pkg::OFF_CSR, 32'h0);
    rdc(rtcs_pkg::OFF_IRQ_MASK, 32'h0);
    rdc(8'h40, 32'h0);
    chk({31'h0, ev}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      kk = 8'($urandom);
      kk = (kk == rtcs_pkg::WR_KEY) ? 8'h00 : kk;
      wr(rtcs_pkg::OFF_CSR, {16'h0, kk, v});
      rdc(rtcs_pkg::OFF_CSR, {24'h0, last});
      apb(1'b1, rtcs_pkg::OFF_CSR, csr(v), 4'h1);
      rdc(rtcs_pkg::OFF_CSR, {24'h0, last});
      // clock select kept at stop so the flags stay quiet
      // match interrupt kept off while auto refresh is enabled
      v = v & 8'h87;
      last = v & 8'h03;
      wr(rtcs_pkg::OFF_CSR, csr(v));
      rdc(rtcs_pkg::OFF_CSR, {24'h0, last});
    end
    wr(rtcs_pkg::OFF_ICONST, csr(8'h01));
    for (int k = 1; k < 8; k++) begin
      wr(rtcs_pkg::OFF_CSR, csr(8'(k << 3)));
      wreq();
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (refresh_req !== 1'b1);
      chk(32'(n), period(k, 1));
    end
    rdc(rtcs_pkg::OFF_CSR, 32'hb8);
    wr(rtcs_pkg::OFF_CSR, csr(8'h80));
    rdc(rtcs_pkg::OFF_CSR, 32'h80);
    refresh_enable <= 1'b0;
    wr(rtcs_pkg::OFF_CSR, csr(8'hc0));
    chkb(0, 1'b1);
    wr(rtcs_pkg::OFF_IRQ_MASK, 32'h0);
    chkb(1, 1'b0);
    wr(rtcs_pkg::OFF_IRQ_MASK, 32'h1);
    chkb(1, 1'b1);
    wr(rtcs_pkg::OFF_IRQ_STATUS, 32'h1);
    chkb(1, 1'b0);
    wr(rtcs_pkg::OFF_CSR, csr(8'h00));
    chkb(0, 1'b0);
    refresh_enable <= 1'b1;
    refresh_mode_select <= 1'b1;
    pulse_done();
    rdc(rtcs_pkg::OFF_CSR, 32'h80);
    refresh_mode_select <= 1'b0;
    pulse_done();
    rdc(rtcs_pkg::OFF_CSR, 32'h0);
    wr(rtcs_pkg::OFF_ICONST, csr(8'h07));
    for (int l = 1; l >= 0; l--) begin
      lim = (l == 1) ? rtcs_pkg::LIMIT_SHORT : rtcs_pkg::LIMIT_LONG;
      wr(rtcs_pkg::OFF_RCNT, {16'h0, rtcs_pkg::WR_KEY_RCNT, 10'(lim - 11'h2)});
      wr(rtcs_pkg::OFF_CSR, csr(8'h08 | 8'(l)));
      wreq();
      rdc(rtcs_pkg::OFF_RCNT, 32'(lim - 11'h1));
      rdc(rtcs_pkg::OFF_CSR, 32'h88 | 32'(l));
      wreq();
      rdc(rtcs_pkg::OFF_RCNT, 32'h0);
      rdc(rtcs_pkg::OFF_CSR, 32'h8c | 32'(l));
      if (l == 1) begin
        wr(rtcs_pkg::OFF_CSR, csr(8'h80));
      end
    end
    chkb(2, 1'b0);
    wr(rtcs_pkg::OFF_CSR, csr(8'h86));
    chkb(2, 1'b1);
    rdc(rtcs_pkg::OFF_CSR, 32'h86);
    wr(rtcs_pkg::OFF_CSR, csr(8'h82));
    rdc(rtcs_pkg::OFF_CSR, 32'h82);
    finish_test();
  end
endmodule
